// ### design/cbx_params.svh
// Constants for the compact branch and trap execute block
`ifndef CBX_PARAMS_SVH
`define CBX_PARAMS_SVH
`define PREFETCH_BYTES 32'h0000_0004
`define HALFWORD_BYTES 32'h0000_0002
`define TRAP_VECTOR 32'h0000_0008
`define COND_UNDEF 4'hE
`define COND_TRAP 4'hF
`define MODE_SUPERVISOR 5'h13
`define FLAG_N 31
`define FLAG_Z 30
`define FLAG_C 29
`define FLAG_V 28
`define STATE_BIT 5
`define MODE_LSB 0
`define MODE_MSB 4
`define LONG_HI_SHIFT 12
`define BRANCH_CYCLES 2'h3
`define TRAP_CYCLES 2'h3
`define NOTAKEN_CYCLES 2'h1
`define LONG_CYCLES 2'h1
`endif

// ### design/cbx_pkg.sv
// Types for the compact branch and trap execute block
package cbx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } exec_state_t;

  typedef struct packed {
    logic [15:0] opcode;
    logic [31:0] inst_addr;
  } exec_req_t;

  typedef struct packed {
    logic pc_load;
    logic [31:0] pc_value;
    logic link_load;
    logic [31:0] link_value;
    logic status_load;
    logic [31:0] status_value;
    logic saved_load;
    logic [31:0] saved_value;
    logic undef_trap;
  } exec_rsp_t;
endpackage

// ### design/cond_eval.sv
// Condition field evaluator against the status flags
`timescale 1ns/1ps
`default_nettype none
module cond_eval (
  input wire logic [3:0] i_cond,
  input wire logic i_n,
  input wire logic i_z,
  input wire logic i_c,
  input wire logic i_v,
  output logic o_pass
);
  always_comb begin
    unique case (i_cond[3:1])
      3'h0: o_pass = i_z;
      3'h1: o_pass = i_c;
      3'h2: o_pass = i_n;
      3'h3: o_pass = i_v;
      3'h4: o_pass = i_c & ~i_z;
      3'h5: o_pass = i_n == i_v;
      3'h6: o_pass = ~i_z & (i_n == i_v);
      3'h7: o_pass = 1'b0;
    endcase
    // Odd codes are the inverse, except the reserved pair
    if (i_cond[3:1] != 3'h7 && i_cond[0]) begin
      o_pass = ~o_pass;
    end
  end
endmodule
`default_nettype wire

// ### design/compact_branch_swi_exec.sv
// Execute logic for compressed branch, trap and long branch formats
`timescale 1ns/1ps
`default_nettype none
`include "cbx_params.svh"
module compact_branch_swi_exec (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire cbx_pkg::exec_req_t i_req,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_link,
  output logic o_ready,
  output logic o_done,
  output cbx_pkg::exec_rsp_t o_rsp
);
  typedef struct packed {
    cbx_pkg::exec_state_t state;
    logic [1:0] cnt;
    logic done;
    logic ready;
    cbx_pkg::exec_rsp_t rsp;
  } core_t;

  core_t state_reg;
  core_t state_next;
  logic cond_pass;

  function automatic logic [31:0] sext_dbl(input logic [10:0] off, input logic [3:0] top);
    logic [31:0] r;
    r = 32'h0000_0000;
    // Sign extend from bit 'top', then double
    for (int i = 0; i < 32; i++) begin
      if (i >= 1 && i <= 11) begin
        r[i] = (i - 1 <= int'(top)) ? off[i-1] : off[top];
      end else if (i > 11) begin
        r[i] = off[top];
      end
    end
    return r;
  endfunction

  cond_eval u_cond (
    .i_cond(i_req.opcode[11:8]),
    .i_n(i_status[`FLAG_N]),
    .i_z(i_status[`FLAG_Z]),
    .i_c(i_status[`FLAG_C]),
    .i_v(i_status[`FLAG_V]),
    .o_pass(cond_pass)
  );

  logic [31:0] base_pc;
  logic [31:0] next_addr;
  logic is_cond;
  logic is_uncond;
  logic is_long;
  logic [3:0] cond;
  logic [10:0] off11;
  logic [31:0] hi_off;
  assign base_pc = i_req.inst_addr + `PREFETCH_BYTES;
  assign next_addr = i_req.inst_addr + `HALFWORD_BYTES;
  assign is_cond = i_req.opcode[15:12] == 4'hD;
  assign is_uncond = i_req.opcode[15:11] == 5'h1C;
  assign is_long = i_req.opcode[15:12] == 4'hF;
  assign cond = i_req.opcode[11:8];
  assign off11 = i_req.opcode[10:0];
  assign hi_off = {{9{off11[10]}}, off11, 12'h000};

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    unique case (state_reg.state)
      cbx_pkg::ST_IDLE: begin
        if (i_valid) begin
          state_next.rsp = '0;
          state_next.rsp.pc_value = next_addr;
          state_next.cnt = `NOTAKEN_CYCLES;
          state_next.state = cbx_pkg::ST_BUSY;
          if (is_cond && cond == `COND_TRAP) begin
            // Comment byte of opcode deliberately unused
            state_next.rsp.link_load = 1'b1;
            state_next.rsp.link_value = next_addr;
            state_next.rsp.saved_load = 1'b1;
            state_next.rsp.saved_value = i_status;
            state_next.rsp.status_load = 1'b1;
            state_next.rsp.status_value = i_status;
            state_next.rsp.status_value[`STATE_BIT] = 1'b0;
            state_next.rsp.status_value[`MODE_MSB:`MODE_LSB] = `MODE_SUPERVISOR;
            state_next.rsp.pc_load = 1'b1;
            state_next.rsp.pc_value = `TRAP_VECTOR;
            state_next.cnt = `TRAP_CYCLES;
          end else if (is_cond && cond == `COND_UNDEF) begin
            state_next.rsp.undef_trap = 1'b1;
          end else if (is_cond && cond_pass) begin
            state_next.rsp.pc_load = 1'b1;
            state_next.rsp.pc_value = base_pc + sext_dbl({3'h0, i_req.opcode[7:0]}, 4'h7);
            state_next.cnt = `BRANCH_CYCLES;
          end else if (is_uncond) begin
            state_next.rsp.pc_load = 1'b1;
            state_next.rsp.pc_value = base_pc + sext_dbl(off11, 4'hA);
            state_next.cnt = `BRANCH_CYCLES;
          end else if (is_long && !i_req.opcode[11]) begin
            state_next.rsp.link_load = 1'b1;
            state_next.rsp.link_value = base_pc + hi_off;
            state_next.cnt = `LONG_CYCLES;
          end else if (is_long) begin
            state_next.rsp.pc_load = 1'b1;
            state_next.rsp.pc_value = i_link + {20'h0_0000, off11, 1'b0};
            state_next.rsp.link_load = 1'b1;
            state_next.rsp.link_value = next_addr | 32'h0000_0001;
            state_next.cnt = `BRANCH_CYCLES;
          end
        end
      end
      cbx_pkg::ST_BUSY: begin
        // Hold results until the cycle budget is spent
        state_next.cnt = state_reg.cnt - 2'h1;
        if (state_reg.cnt == 2'h1) begin
          state_next.state = cbx_pkg::ST_DONE;
          state_next.done = 1'b1;
        end
      end
      cbx_pkg::ST_DONE: begin
        state_next.state = cbx_pkg::ST_IDLE;
      end
      default: begin
        state_next.state = cbx_pkg::ST_IDLE;
      end
    endcase
    // Ready lives in the state word so the output comes straight off a flop
    state_next.ready = state_next.state == cbx_pkg::ST_IDLE;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= '{state: cbx_pkg::ST_IDLE, cnt: 2'h0, done: 1'b0, ready: 1'b1, rsp: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_ready = state_reg.ready;
  assign o_done = state_reg.done;
  assign o_rsp = state_reg.rsp;

  property p_trap_vector;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond == `COND_TRAP) |=> (o_rsp.pc_value == 32'h8 && o_rsp.saved_load);
  endproperty
  a_trap_vector: assert property (p_trap_vector) else $error("trap vector wrong");

  property p_trap_mode;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond == `COND_TRAP) |=>
      (o_rsp.status_value[4:0] == 5'h13 && !o_rsp.status_value[5]);
  endproperty
  a_trap_mode: assert property (p_trap_mode) else $error("trap mode wrong");

  property p_undef;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond == `COND_UNDEF) |=> (o_rsp.undef_trap && !o_rsp.pc_load);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code branched");

  property p_notaken;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond < 4'hE && !cond_pass) |=>
      (!o_rsp.pc_load && !o_rsp.link_load && o_rsp.pc_value == $past(i_req.inst_addr) + 32'h2);
  endproperty
  a_notaken: assert property (p_notaken) else $error("not taken changed state");

  property p_cond_target;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond < 4'hE && cond_pass) |=> (o_rsp.pc_value == $past(i_req.inst_addr) + 32'h4 +
      {{23{$past(i_req.opcode[7])}}, $past(i_req.opcode[7:0]), 1'b0});
  endproperty
  a_cond_target: assert property (p_cond_target) else $error("cond target wrong");

  property p_branch_time;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_uncond) |=> !o_done [*3] ##1 o_done;
  endproperty
  a_branch_time: assert property (p_branch_time) else $error("branch cycle count wrong");

  property p_trap_time;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_cond && cond == `COND_TRAP) |=> !o_done [*3] ##1 o_done;
  endproperty
  a_trap_time: assert property (p_trap_time) else $error("trap cycle count wrong");

  property p_uncond_target;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_uncond) |=> (o_rsp.pc_load && o_rsp.pc_value == $past(i_req.inst_addr) + 32'h4 +
      {{20{$past(i_req.opcode[10])}}, $past(i_req.opcode[10:0]), 1'b0});
  endproperty
  a_uncond_target: assert property (p_uncond_target) else $error("uncond target wrong");

  property p_long_hi;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_long && !i_req.opcode[11]) |=> (!o_rsp.pc_load && o_rsp.link_value ==
      $past(i_req.inst_addr) + 32'h4 + {{9{$past(i_req.opcode[10])}}, $past(i_req.opcode[10:0]), 12'h000});
  endproperty
  a_long_hi: assert property (p_long_hi) else $error("long first half wrong");

  property p_long_lo;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_long && i_req.opcode[11]) |=> (o_rsp.link_value[0] && o_rsp.pc_load);
  endproperty
  a_long_lo: assert property (p_long_lo) else $error("long second half wrong");

  property p_long_lo_target;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (o_ready && i_valid && is_long && i_req.opcode[11]) |=>
      (o_rsp.pc_value == $past(i_link) + {20'h0_0000, $past(i_req.opcode[10:0]), 1'b0} &&
      o_rsp.link_value == (($past(i_req.inst_addr) + 32'h2) | 32'h0000_0001));
  endproperty
  a_long_lo_target: assert property (p_long_lo_target) else $error("long second half target wrong");
endmodule
`default_nettype wire

// ### dv/compact_branch_swi_exec_bench.sv
// Self-checking testbench for the compact branch and trap execute block
`timescale 1ns/1ps
`default_nettype none
module compact_branch_swi_exec_bench;
  logic i_mclk, i_sys_rst, i_valid, o_ready, o_done;
  cbx_pkg::exec_req_t i_req;
  logic [31:0] i_status, i_link;
  cbx_pkg::exec_rsp_t o_rsp;
  int miscompares, compares, ncyc;
  compact_branch_swi_exec dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_req(i_req),
    .i_status(i_status), .i_link(i_link), .o_ready(o_ready), .o_done(o_done), .o_rsp(o_rsp));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One instruction; a stray strobe with another opcode while busy must be ignored
  task automatic exec(input logic [15:0] op, input logic [31:0] a, input logic [31:0] st, input logic [31:0] lk);
    while (o_ready !== 1'b1) begin
      @(posedge i_mclk);
      #1;
    end
    i_req = '{opcode: op, inst_addr: a};
    i_status = st;
    i_link = lk;
    i_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_req.opcode = ~op;
    @(posedge i_mclk);
    #1 i_valid = 1'b0;
    i_req.opcode = op;
    ncyc = 1;
    while (o_done !== 1'b1 && ncyc < 20) begin
      @(posedge i_mclk);
      #1 ncyc++;
    end
  endtask
  task automatic no_side();
    chk({28'h0, o_rsp.link_load, o_rsp.status_load, o_rsp.saved_load, o_rsp.undef_trap}, 32'h0);
  endtask
  function automatic logic cpass(input logic [3:0] c, input logic n, z, cf, v);
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cf;
      4'h3: return !cf;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cf && !z;
      4'h9: return !cf || z;
      4'hA: return n == v;
      4'hB: return n != v;
      4'hC: return !z && (n == v);
      default: return z || (n != v);
    endcase
  endfunction
  task automatic t_reset();
    chk({30'h0, o_ready, o_done}, 32'h2);
    chkb(o_rsp === '0, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_cond();
    logic [7:0] o;
    logic p;
    for (int c = 0; c < 14; c++) begin
      for (int f = 0; f < 16; f++) begin
        o = c[0] ? 8'h7F : 8'h80;
        p = cpass(c[3:0], f[3], f[2], f[1], f[0]);
        exec({4'hD, c[3:0], o}, 32'h0000_1000 + 32'(f * 2), {f[3:0], 28'h0}, 32'h0);
        chkb(o_rsp.pc_load, p);
        if (p)
          chk(o_rsp.pc_value, 32'h0000_1004 + 32'(f * 2) + {{23{o[7]}}, o, 1'b0});
        else
          chk(o_rsp.pc_value, 32'h0000_1002 + 32'(f * 2));
        no_side();
        chk(ncyc, p ? 32'h3 : 32'h1);
      end
    end
    $display("conditional branch test done");
  endtask
  task automatic t_trap();
    logic [31:0] st;
    st = 32'hA000_0030;
    for (int k = 0; k < 2; k++) begin
      exec({8'hDF, k[0] ? 8'hFF : 8'h12}, 32'h0000_2000, st, 32'h0);
      chkb(o_rsp.pc_load, 1'b1);
      chk(o_rsp.pc_value, 32'h0000_0008);
      chk(o_rsp.link_value, 32'h0000_2002);
      chk({o_rsp.link_load, o_rsp.saved_load, o_rsp.status_load}, 32'h7);
      chk(o_rsp.saved_value, st);
      chk(o_rsp.status_value, {st[31:6], 1'b0, 5'h13});
      chk(ncyc, 32'h3);
    end
    $display("trap test done");
  endtask
  task automatic t_undef();
    exec(16'hDE5A, 32'h0000_3000, 32'hF000_0000, 32'h0);
    chk({o_rsp.pc_load, o_rsp.link_load, o_rsp.status_load, o_rsp.saved_load, o_rsp.undef_trap}, 32'h1);
    chk(ncyc, 32'h1);
    exec(16'h0000, 32'h0000_3010, 32'h0, 32'h0);
    chkb(o_rsp.pc_load, 1'b0);
    chk(o_rsp.pc_value, 32'h0000_3012);
    $display("undefined test done");
  endtask
  task automatic t_uncond();
    logic [10:0] tbl [3] = '{11'h7FE, 11'h3FF, 11'h400};
    foreach (tbl[i]) begin
      exec({5'h1C, tbl[i]}, 32'h0000_8000, 32'h0, 32'h0);
      chkb(o_rsp.pc_load, 1'b1);
      chk(o_rsp.pc_value, 32'h0000_8004 + {{20{tbl[i][10]}}, tbl[i], 1'b0});
      chk(ncyc, 32'h3);
    end
    $display("unconditional branch test done");
  endtask
  task automatic t_long();
    logic [10:0] hi [2] = '{11'h400, 11'h3FF};
    logic [10:0] lo [2] = '{11'h7FF, 11'h000};
    logic [31:0] lk;
    foreach (hi[i]) begin
      lk = 32'h0040_0004 + {{9{hi[i][10]}}, hi[i], 12'h000};
      exec({5'h1E, hi[i]}, 32'h0040_0000, 32'h0, 32'h0);
      chkb(o_rsp.link_load, 1'b1);
      chk(o_rsp.link_value, lk);
      chkb(o_rsp.pc_load, 1'b0);
      exec({5'h1F, lo[i]}, 32'h0040_0002, 32'h0, lk);
      chk(o_rsp.pc_value, lk + {20'h0, lo[i], 1'b0});
      chk(o_rsp.link_value, 32'h0040_0005);
      chkb(o_rsp.pc_load, 1'b1);
    end
    $display("long branch test done");
  endtask
  // Reset in mid-run must clear a response left standing by the last branch
  task automatic t_reset_again();
    i_sys_rst = 1'b1;
    @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    t_reset();
  endtask
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    i_sys_rst = 1'b1;
    i_valid = 1'b0;
    i_req = '0;
    i_status = 32'h0;
    i_link = 32'h0;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    t_reset();
    t_cond();
    t_trap();
    t_undef();
    t_uncond();
    t_long();
    t_reset_again();
    end_sim();
  end
endmodule
`default_nettype wire
